// [smp_backoff.v]
// Half-duplex collision back-off slot generator with excessive-collision handling.
`timescale 1ns/1ps
`include "smp_defines.vh"

module smp_backoff (
  input  wire       i_clk,
  input  wire       i_sys_rst,
  input  wire       i_half_duplex,
  input  wire       i_collision,
  input  wire       i_tx_done,
  input  wire       i_alt_mode,
  input  wire       i_agg_mode,
  input  wire       i_no_exc_drop,
  output reg        o_bo_valid,
  output reg  [9:0] o_bo_slots,
  output reg        o_exc_drop,
  output reg  [4:0] o_coll_cnt
);

  reg  [15:0] lfsr_q;
  reg  [4:0]  n_coll;
  reg  [4:0]  exp_cap;
  reg  [4:0]  exp_use;

  // --------------------------------------------------------------------------
  // Slot mask of 2^exp - 1, capped at ten bits.
  // --------------------------------------------------------------------------
  function [9:0] slot_mask;
    input [4:0] exp;
    begin
      if (exp >= `SMP_BO_STD_EXP) begin
        slot_mask = 10'h3ff;
      end else begin
        slot_mask = (10'h001 << exp) - 10'h001;
      end
    end
  endfunction

  always @* begin
    n_coll = o_coll_cnt + 5'h01;
    exp_cap = `SMP_BO_STD_EXP;
    if (i_agg_mode) begin
      exp_cap = `SMP_BO_AGG_EXP;
    end else if (i_alt_mode) begin
      exp_cap = `SMP_BO_ALT_EXP;
    end
    exp_use = (n_coll < exp_cap) ? n_coll : exp_cap;
  end

  // --------------------------------------------------------------------------
  // Collision counting and slot selection.
  // --------------------------------------------------------------------------
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      lfsr_q     <= `SMP_LFSR_SEED;
      o_bo_valid <= 1'b0;
      o_bo_slots <= 10'h000;
      o_exc_drop <= 1'b0;
      o_coll_cnt <= 5'h00;
    end else begin
      lfsr_q     <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      o_bo_valid <= 1'b0;
      o_exc_drop <= 1'b0;
      if (!i_half_duplex) begin
        o_coll_cnt <= 5'h00;
      end else if (i_collision) begin
        if (n_coll >= `SMP_MAX_COLL) begin
          if (i_no_exc_drop) begin
            o_bo_valid <= 1'b1;
            o_bo_slots <= lfsr_q[9:0] & slot_mask(exp_cap);
            o_coll_cnt <= i_alt_mode ? 5'h00 : 5'h0f;
          end else begin
            o_exc_drop <= 1'b1;
            o_coll_cnt <= 5'h00;
          end
        end else begin
          o_bo_valid <= 1'b1;
          o_bo_slots <= lfsr_q[9:0] & slot_mask(exp_use);
          o_coll_cnt <= n_coll;
        end
      end else if (i_tx_done) begin
        o_coll_cnt <= 5'h00;
      end
    end
  end

endmodule

// [smp_defines.vh]
// Register map, field positions, reset values and frame constants of the MAC policy block.
`ifndef SMP_DEFINES_VH
`define SMP_DEFINES_VH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define SMP_ADDR_CTRL0      12'h330
`define SMP_ADDR_CTRL1      12'h334
`define SMP_ADDR_STAT       12'h338
`define SMP_ADDR_BITS       12

// ----------------------------------------------------------------------------
// Policy control zero fields and reset value
// ----------------------------------------------------------------------------
`define SMP_C0_ALT_BO       7
`define SMP_C0_LEN_CHK      3
`define SMP_C0_FC_DROP      1
`define SMP_C0_AGG_BO       0
`define SMP_C0_RESET        8'h0e

// ----------------------------------------------------------------------------
// Policy control one fields and reset value
// ----------------------------------------------------------------------------
`define SMP_C1_NO_EXC_DROP  0
`define SMP_C1_RESET        8'h00

// ----------------------------------------------------------------------------
// Status register field positions
// ----------------------------------------------------------------------------
`define SMP_ST_LEN_LSB      0
`define SMP_ST_PAUSE_LSB    8
`define SMP_ST_EXC_LSB      16
`define SMP_ST_COLL_LSB     24

// ----------------------------------------------------------------------------
// Frame constants
// ----------------------------------------------------------------------------
`define SMP_LEN_LIMIT       16'h05dc
`define SMP_PAUSE_TYPE      16'h8808
`define SMP_PAUSE_DA        48'h0180c2000001

// ----------------------------------------------------------------------------
// Back-off constants
// ----------------------------------------------------------------------------
`define SMP_MAX_COLL        5'h10
`define SMP_BO_STD_EXP      5'h0a
`define SMP_BO_ALT_EXP      5'h06
`define SMP_BO_AGG_EXP      5'h02
`define SMP_LFSR_SEED       16'hace1

`endif

// [smp_link_partner.sv]
// Link-side model that presents frame summaries and collision events.
`timescale 1ns/1ps
module smp_link_partner (
  input  wire        i_clk,
  output reg         o_frm_valid,
  output reg  [15:0] o_frm_type,
  output reg  [47:0] o_frm_da,
  output reg  [15:0] o_frm_len,
  output reg         o_half_duplex,
  output reg         o_collision,
  output reg         o_tx_done
);
  initial begin
    {o_frm_valid, o_frm_type, o_frm_da, o_frm_len} = 81'h0;
    {o_half_duplex, o_collision, o_tx_done} = 3'h0;
  end
  // Fields are inverted after the pulse so stale values are never trusted.
  task send_frame(input [15:0] t, input [47:0] d, input [15:0] l);
    @(posedge i_clk);
    {o_frm_valid, o_frm_type, o_frm_da, o_frm_len} <= {1'b1, t, d, l};
    @(posedge i_clk);
    {o_frm_valid, o_frm_type, o_frm_da, o_frm_len} <= {1'b0, ~t, ~d, ~l};
  endtask
  task collide;
    @(posedge i_clk);
    o_collision <= 1'b1;
    @(posedge i_clk);
    o_collision <= 1'b0;
  endtask
  task finish_tx;
    @(posedge i_clk);
    o_tx_done <= 1'b1;
    @(posedge i_clk);
    o_tx_done <= 1'b0;
  endtask
  task set_half(input b);
    @(posedge i_clk);
    o_half_duplex <= b;
    @(posedge i_clk);
  endtask
endmodule

// [smp_mac_policy.v]
// MAC frame policy control block with AHB-Lite register slave.
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "smp_defines.vh"

module smp_mac_policy (
  input  wire        i_clk,
  input  wire        i_sys_rst,
  input  wire        i_hsel,
  input  wire [31:0] i_haddr,
  input  wire [1:0]  i_htrans,
  input  wire        i_hwrite,
  input  wire [2:0]  i_hsize,
  input  wire [31:0] i_hwdata,
  input  wire        i_hready,
  output reg         o_hreadyout,
  output reg         o_hresp,
  output reg  [31:0] o_hrdata,
  input  wire        i_frm_valid,
  input  wire [15:0] i_frm_type,
  input  wire [47:0] i_frm_da,
  input  wire [15:0] i_frm_len,
  output reg         o_frm_done,
  output reg         o_frm_drop,
  output reg  [1:0]  o_frm_reason,
  input  wire        i_half_duplex,
  input  wire        i_collision,
  input  wire        i_tx_done,
  output reg         o_alt_backoff,
  output reg         o_agg_backoff,
  output wire        o_bo_valid,
  output wire [9:0]  o_bo_slots,
  output wire        o_exc_drop
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  reg  [7:0]                 ctrl0_q;
  reg  [7:0]                 ctrl0_d;
  reg  [7:0]                 ctrl1_q;
  reg  [7:0]                 ctrl1_d;
  reg  [7:0]                 len_cnt_q;
  reg  [7:0]                 pause_cnt_q;
  reg  [7:0]                 exc_cnt_q;
  reg                        wr_pend_q;
  reg  [`SMP_ADDR_BITS-1:0]  wr_addr_q;
  reg  [31:0]                rd_mux;
  reg                        len_bad;
  reg                        type_hit;
  reg                        da_hit;
  reg                        pause_bad;
  wire                       addr_phase;
  wire [`SMP_ADDR_BITS-1:0]  addr_word;
  wire [4:0]                 coll_cnt;

  // --------------------------------------------------------------------------
  // Shared helpers
  // --------------------------------------------------------------------------
  function [7:0] sat_inc;
    input [7:0] v;
    begin
      if (v == 8'hff) begin
        sat_inc = v;
      end else begin
        sat_inc = v + 8'h01;
      end
    end
  endfunction

  // --------------------------------------------------------------------------
  // AHB-Lite address phase decode
  // --------------------------------------------------------------------------
  assign addr_phase = i_hsel & i_hready & i_htrans[1];
  assign addr_word  = {i_haddr[`SMP_ADDR_BITS-1:2], 2'b00};

  // --------------------------------------------------------------------------
  // Register write data path
  // --------------------------------------------------------------------------
  always @* begin
    ctrl0_d = ctrl0_q;
    ctrl1_d = ctrl1_q;
    if (wr_pend_q) begin
      if (wr_addr_q == `SMP_ADDR_CTRL0) begin
        ctrl0_d = i_hwdata[7:0];
      end
      if (wr_addr_q == `SMP_ADDR_CTRL1) begin
        ctrl1_d = i_hwdata[7:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Read multiplexer, forwarded from the pending write
  // --------------------------------------------------------------------------
  always @* begin
    rd_mux = 32'h0000_0000;
    case (addr_word)
      `SMP_ADDR_CTRL0: begin
        rd_mux = {24'h00_0000, ctrl0_d};
      end
      `SMP_ADDR_CTRL1: begin
        rd_mux = {24'h00_0000, ctrl1_d};
      end
      `SMP_ADDR_STAT: begin
        rd_mux[`SMP_ST_LEN_LSB +: 8]   = len_cnt_q;
        rd_mux[`SMP_ST_PAUSE_LSB +: 8] = pause_cnt_q;
        rd_mux[`SMP_ST_EXC_LSB +: 8]   = exc_cnt_q;
        rd_mux[`SMP_ST_COLL_LSB +: 5]  = coll_cnt;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // AHB-Lite slave: zero wait states, always OKAY
  // --------------------------------------------------------------------------
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
      o_hrdata    <= 32'h0000_0000;
      wr_pend_q   <= 1'b0;
      wr_addr_q   <= {`SMP_ADDR_BITS{1'b0}};
      ctrl0_q     <= `SMP_C0_RESET;
      ctrl1_q     <= `SMP_C1_RESET;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
      ctrl0_q     <= ctrl0_d;
      ctrl1_q     <= ctrl1_d;
      if (i_hready) begin
        wr_pend_q <= addr_phase & i_hwrite;
        wr_addr_q <= addr_word;
        if (addr_phase & !i_hwrite) begin
          o_hrdata <= rd_mux;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Back-off controls seen by the MAC, gated by duplex
  // --------------------------------------------------------------------------
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_alt_backoff <= 1'b0;
      o_agg_backoff <= 1'b0;
    end else begin
      o_alt_backoff <= ctrl0_q[`SMP_C0_ALT_BO] & i_half_duplex;
      o_agg_backoff <= ctrl0_q[`SMP_C0_AGG_BO] & i_half_duplex;
    end
  end

  // --------------------------------------------------------------------------
  // Collision back-off engine
  // --------------------------------------------------------------------------
  smp_backoff u_backoff (
    .i_clk         (i_clk),
    .i_sys_rst     (i_sys_rst),
    .i_half_duplex (i_half_duplex),
    .i_collision   (i_collision),
    .i_tx_done     (i_tx_done),
    .i_alt_mode    (ctrl0_q[`SMP_C0_ALT_BO]),
    .i_agg_mode    (ctrl0_q[`SMP_C0_AGG_BO]),
    .i_no_exc_drop (ctrl1_q[`SMP_C1_NO_EXC_DROP]),
    .o_bo_valid    (o_bo_valid),
    .o_bo_slots    (o_bo_slots),
    .o_exc_drop    (o_exc_drop),
    .o_coll_cnt    (coll_cnt)
  );

  // --------------------------------------------------------------------------
  // Received frame checks
  // --------------------------------------------------------------------------
  always @* begin
    len_bad   = ctrl0_q[`SMP_C0_LEN_CHK] & (i_frm_type < `SMP_LEN_LIMIT)
                & (i_frm_len != i_frm_type);
    type_hit  = (i_frm_type == `SMP_PAUSE_TYPE);
    da_hit    = (i_frm_da == `SMP_PAUSE_DA);
    if (ctrl0_q[`SMP_C0_FC_DROP]) begin
      pause_bad = type_hit | da_hit;
    end else begin
      pause_bad = type_hit & da_hit;
    end
  end

  // --------------------------------------------------------------------------
  // Frame verdict, one cycle after the frame strobe
  // --------------------------------------------------------------------------
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_frm_done   <= 1'b0;
      o_frm_drop   <= 1'b0;
      o_frm_reason <= 2'h0;
    end else begin
      o_frm_done <= i_frm_valid;
      if (i_frm_valid) begin
        o_frm_drop   <= len_bad | pause_bad;
        o_frm_reason <= {pause_bad, len_bad};
      end
    end
  end

  // --------------------------------------------------------------------------
  // Saturating drop counters
  // --------------------------------------------------------------------------
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      len_cnt_q   <= 8'h00;
      pause_cnt_q <= 8'h00;
      exc_cnt_q   <= 8'h00;
    end else begin
      if (i_frm_valid & len_bad) begin
        len_cnt_q <= sat_inc(len_cnt_q);
      end
      if (i_frm_valid & pause_bad) begin
        pause_cnt_q <= sat_inc(pause_cnt_q);
      end
      if (o_exc_drop) begin
        exc_cnt_q <= sat_inc(exc_cnt_q);
      end
    end
  end

endmodule

// [smp_mac_policy_assertions.sv]
// Port assertions of the MAC policy block.
`timescale 1ns/1ps
`include "smp_defines.vh"
module smp_mac_policy_assertions (
  input wire        i_clk,
  input wire        i_sys_rst,
  input wire        i_frm_valid,
  input wire [15:0] i_frm_type,
  input wire [47:0] i_frm_da,
  input wire [15:0] i_frm_len,
  input wire        o_frm_done,
  input wire        o_frm_drop,
  input wire [1:0]  o_frm_reason,
  input wire        i_half_duplex,
  input wire        i_collision,
  input wire        o_alt_backoff,
  input wire        o_agg_backoff,
  input wire        o_bo_valid,
  input wire [9:0]  o_bo_slots,
  input wire        o_exc_drop
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  chk_frm_done: assert property (
    o_frm_done == $past(i_frm_valid)) else $error("frame verdict timing wrong");
  chk_len_pass: assert property (
    i_frm_valid && (i_frm_type >= `SMP_LEN_LIMIT || i_frm_type == i_frm_len)
    |=> !o_frm_reason[0]) else $error("length drop without cause");
  chk_both_drop: assert property (
    i_frm_valid && i_frm_type == `SMP_PAUSE_TYPE && i_frm_da == `SMP_PAUSE_DA
    |=> o_frm_drop) else $error("pause frame kept");
  chk_plain_drop: assert property (
    i_frm_valid && i_frm_type != `SMP_PAUSE_TYPE && i_frm_da != `SMP_PAUSE_DA
    |=> o_frm_drop == o_frm_reason[0]) else $error("plain frame verdict wrong");
  chk_fd_modes: assert property (
    !i_half_duplex |=> !o_alt_backoff && !o_agg_backoff) else $error("mode shown in full duplex");
  chk_fd_quiet: assert property (
    i_collision && !i_half_duplex |=> !o_bo_valid && !o_exc_drop) else $error("full duplex backoff");
  chk_bo_answer: assert property (
    i_collision && i_half_duplex |=> o_bo_valid ^ o_exc_drop) else $error("collision unanswered");
  chk_bo_cause: assert property (
    o_bo_valid || o_exc_drop |-> $past(i_collision && i_half_duplex)) else $error("stray backoff");
  chk_agg_cap: assert property (
    i_collision && i_half_duplex && o_agg_backoff
    |=> o_exc_drop || o_bo_slots < 10'h004) else $error("aggressive window too wide");
  chk_alt_cap: assert property (
    i_collision && i_half_duplex && o_alt_backoff && !o_agg_backoff
    |=> o_exc_drop || o_bo_slots < 10'h040) else $error("alternate window too wide");
endmodule

// [tb.sv]
// Self-checking bench of the MAC policy block.
`timescale 1ns/1ps
`include "smp_defines.vh"
module tb;
  reg         i_clk, i_sys_rst, i_hsel, i_hwrite;
  reg  [31:0] i_haddr, i_hwdata, rdat;
  reg  [1:0]  i_htrans;
  reg  [2:0]  i_hsize;
  wire        i_frm_valid, i_half_duplex, i_collision, i_tx_done, o_hreadyout, o_hresp;
  wire        o_frm_done, o_frm_drop, o_alt_backoff, o_agg_backoff, o_bo_valid, o_exc_drop;
  wire [15:0] i_frm_type, i_frm_len;
  wire [47:0] i_frm_da;
  wire [31:0] o_hrdata;
  wire [1:0]  o_frm_reason;
  wire [9:0]  o_bo_slots;
  integer     n_mismatch, n_tests;
  localparam [47:0] OTH = 48'h020000000001;
  localparam [47:0] PDA = `SMP_PAUSE_DA;
  smp_mac_policy smp_mac_policy_inst (.i_clk, .i_sys_rst, .i_hsel, .i_haddr, .i_htrans, .i_hwrite,
    .i_hsize, .i_hwdata, .i_hready(o_hreadyout), .o_hreadyout, .o_hresp, .o_hrdata, .i_frm_valid,
    .i_frm_type, .i_frm_da, .i_frm_len, .o_frm_done, .o_frm_drop, .o_frm_reason, .i_half_duplex,
    .i_collision, .i_tx_done, .o_alt_backoff, .o_agg_backoff, .o_bo_valid, .o_bo_slots, .o_exc_drop);
  smp_link_partner smp_link_partner_inst (.i_clk, .o_frm_valid(i_frm_valid),
    .o_frm_type(i_frm_type), .o_frm_da(i_frm_da), .o_frm_len(i_frm_len),
    .o_half_duplex(i_half_duplex), .o_collision(i_collision), .o_tx_done(i_tx_done));
  task check(input string what, input [31:0] exp, input [31:0] got);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task ahb(input w, input [31:0] a, input [31:0] d);
    @(posedge i_clk);
    {i_hsel, i_haddr, i_htrans, i_hwrite} <= {1'b1, a, 2'b10, w};
    @(posedge i_clk);
    while (o_hreadyout !== 1'b1) @(posedge i_clk);
    {i_hsel, i_htrans, i_hwdata} <= {1'b0, 2'b00, d};
    @(posedge i_clk);
    while (o_hreadyout !== 1'b1) @(posedge i_clk);
    rdat = o_hrdata;
  endtask
  task rd(input [31:0] a, input [31:0] exp);
    ahb(1'b0, a, 32'h0);
    check("register", exp, rdat);
    check("response", 32'h0, {31'h0, o_hresp});
  endtask
  task frm(input [15:0] t, input [47:0] d, input [15:0] l, input drop, input len_bad);
    smp_link_partner_inst.send_frame(t, d, l);
    #1;
    check("done", 32'h1, {31'h0, o_frm_done});
    check("drop", {31'h0, drop}, {31'h0, o_frm_drop});
    check("length", {31'h0, len_bad}, {31'h0, o_frm_reason[0]});
    check("pause", {31'h0, drop & ~len_bad}, {31'h0, o_frm_reason[1]});
  endtask
  task coll(input bo, input exc, input [9:0] lim);
    smp_link_partner_inst.collide;
    #1;
    check("slots valid", {31'h0, bo}, {31'h0, o_bo_valid});
    check("excess drop", {31'h0, exc}, {31'h0, o_exc_drop});
    if (bo) check("slot range", 32'h1, {31'h0, o_bo_slots < lim});
  endtask
  task close_out;
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  initial begin
    repeat (5000) @(posedge i_clk);
    n_mismatch = n_mismatch + 1;
    close_out;
  end
  initial begin
    {n_mismatch, n_tests, i_sys_rst, i_hsel, i_hwrite} = 67'h4;
    {i_haddr, i_hwdata, i_htrans, i_hsize} = 69'h2;
    repeat (20) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rd(32'h330, 32'h0e);
    rd(32'h334, 32'h00);
    rd(32'h3fc, 32'h00);
    frm(16'h8808, OTH, 16'h0040, 1'b1, 1'b0);
    frm(16'h0800, PDA, 16'h0040, 1'b1, 1'b0);
    frm(16'h0040, OTH, 16'h0041, 1'b1, 1'b1);
    frm(16'h05db, OTH, 16'h05db, 1'b0, 1'b0);
    frm(16'h05dc, OTH, 16'h0000, 1'b0, 1'b0);
    ahb(1'b1, 32'h330, 32'h04);
    rd(32'h330, 32'h04);
    frm(16'h8808, OTH, 16'h0040, 1'b0, 1'b0);
    frm(16'h0800, PDA, 16'h0040, 1'b0, 1'b0);
    frm(16'h8808, PDA, 16'h0040, 1'b1, 1'b0);
    frm(16'h0040, OTH, 16'h0041, 1'b0, 1'b0);
    smp_link_partner_inst.set_half(1'b1);
    ahb(1'b1, 32'h330, 32'h01);
    repeat (2) @(posedge i_clk);
    #1;
    check("aggressive", 32'h1, {31'h0, o_agg_backoff});
    coll(1'b1, 1'b0, 10'h004);
    smp_link_partner_inst.set_half(1'b0);
    @(posedge i_clk);
    #1;
    check("aggressive", 32'h0, {31'h0, o_agg_backoff});
    coll(1'b0, 1'b0, 10'h000);
    ahb(1'b1, 32'h330, 32'h80);
    smp_link_partner_inst.set_half(1'b1);
    smp_link_partner_inst.finish_tx;
    #1;
    check("alternate", 32'h1, {31'h0, o_alt_backoff});
    repeat (15) coll(1'b1, 1'b0, 10'h040);
    coll(1'b0, 1'b1, 10'h000);
    ahb(1'b1, 32'h334, 32'h01);
    rd(32'h334, 32'h01);
    smp_link_partner_inst.finish_tx;
    repeat (16) coll(1'b1, 1'b0, 10'h040);
    rd(32'h338, 32'h0001_0301);
    close_out;
  end
endmodule
bind smp_mac_policy smp_mac_policy_assertions smp_mac_policy_assertions_inst (.i_clk, .i_sys_rst,
  .i_frm_valid, .i_frm_type, .i_frm_da, .i_frm_len, .o_frm_done, .o_frm_drop, .o_frm_reason,
  .i_half_duplex, .i_collision, .o_alt_backoff, .o_agg_backoff, .o_bo_valid, .o_bo_slots,
  .o_exc_drop);
